// ===== design/udrt_timer.sv
// Top of the up/down reload timer with clock output, reached over APB.
// Assumes pclk is the oscillator clock and presetn the core reset.
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "udrt_defs.svh"

module udrt_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic count_pin_i,
    output logic count_pin_o,
    output logic count_pin_oe,
    input wire logic direction_capture_pin_i,
    output logic timer_irq_req,
    output logic baud_tick
);

    // Register address decode, used by the read mux and the write strobes.
    function automatic logic udrt_hit(input logic [7:0] addr, input logic [7:0] offs);
        udrt_hit = (addr == offs);
    endfunction : udrt_hit

    udrt_regbus_if bus (); // Register path from the APB front end.

    // Software-visible state.
    logic [7:0] ctrl_ff; // timer_control_register.
    logic [1:0] mode_ff; // mode_control_register, clock_output_enable and updown_enable_bit.
    logic [7:0] count_low_byte_ff; // Low count byte.
    logic [7:0] count_high_byte_ff; // High count byte.
    logic [7:0] reload_low_byte_ff; // Low reload or capture byte.
    logic [7:0] reload_high_byte_ff; // High reload or capture byte.

    // Internal timing state.
    logic [3:0] pre_ff; // Divide-by-twelve prescaler.
    logic half_ff; // Divide-by-two phase for the fast modes.
    logic pin_out_ff; // Clock-out level.
    logic pin_oe_ff; // Drive enable of the shared pin.
    logic irq_ff; // Registered interrupt request.
    logic baud_ff; // Registered baud overflow pulse.

    // Synchronised pins: bit 0 is the count pin, bit 1 the direction pin.
    logic [1:0] pin_lvl;
    logic [1:0] pin_fall;

    udrt_apb u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pready(pready),
        .prdata(prdata),
        .pslverr(pslverr),
        .bus(bus)
    );

    udrt_pinsync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_i({direction_capture_pin_i, count_pin_i}),
        .level_o(pin_lvl),
        .fall_o(pin_fall)
    );

    // Control bit views.
    wire overflow_flag = ctrl_ff[`UDRT_CTRL_OVF];
    wire external_flag = ctrl_ff[`UDRT_CTRL_EXF];
    wire receive_clock_select = ctrl_ff[`UDRT_CTRL_RCLK];
    wire transmit_clock_select = ctrl_ff[`UDRT_CTRL_TRANSMIT_CLOCK_SELECT];
    wire external_enable_bit = ctrl_ff[`UDRT_CTRL_EXEN];
    wire run_control_bit = ctrl_ff[`UDRT_CTRL_RUN];
    wire counter_select_bit = ctrl_ff[`UDRT_CTRL_CT];
    wire capture_reload_select = ctrl_ff[`UDRT_CTRL_CPRL];
    wire clock_output_enable = mode_ff[`UDRT_MODE_OE];
    wire updown_enable_bit = mode_ff[`UDRT_MODE_UPDOWN_ENABLE_BIT];

    // Write strobes, one per register.
    wire wr_ctrl = bus.wr_en & udrt_hit(bus.addr, `UDRT_OFF_CTRL);
    wire wr_mode = bus.wr_en & udrt_hit(bus.addr, `UDRT_OFF_MODE);
    wire wr_cntl = bus.wr_en & udrt_hit(bus.addr, `UDRT_OFF_CNTL);
    wire wr_cnth = bus.wr_en & udrt_hit(bus.addr, `UDRT_OFF_CNTH);
    wire wr_rldl = bus.wr_en & udrt_hit(bus.addr, `UDRT_OFF_RLDL);
    wire wr_rldh = bus.wr_en & udrt_hit(bus.addr, `UDRT_OFF_RLDH);

    // Mode selection; either serial select overrides the capture select.
    wire baud_sel = receive_clock_select | transmit_clock_select;
    udrt_pkg::udrt_mode_t mode; // Current operating mode.
    assign mode = baud_sel ? udrt_pkg::UDRT_BAUD :
        capture_reload_select ? udrt_pkg::UDRT_CAPTURE :
        updown_enable_bit ? udrt_pkg::UDRT_UPDOWN : udrt_pkg::UDRT_RELOAD;

    // Clock-out needs timer operation; a set counter select keeps the pin an input.
    wire clkout = clock_output_enable & ~counter_select_bit;

    // Count input selection.
    wire tick12 = (pre_ff == `UDRT_PRE_LAST);
    wire tick2 = half_ff;
    wire fast = clkout | (mode == udrt_pkg::UDRT_BAUD);
    wire src_tick = counter_select_bit ? pin_fall[0] : (fast ? tick2 : tick12);
    wire inc = run_control_bit & src_tick;

    // Direction follows the synchronised pin only in up/down mode.
    wire is_updown = (mode == udrt_pkg::UDRT_UPDOWN);
    wire down = is_updown & ~pin_lvl[1];

    // Cascaded bytes: the low byte carry steps the high byte.
    wire [15:0] count = {count_high_byte_ff, count_low_byte_ff};
    wire [15:0] reload = {reload_high_byte_ff, reload_low_byte_ff};
    wire [8:0] low_up = {1'b0, count_low_byte_ff} + 9'h001;
    wire [7:0] high_up = count_high_byte_ff + {7'h00, low_up[8]};
    wire [15:0] count_dn = count - 16'h0001;

    // Wrap detection: past FFFFh going up, equal to reload going down.
    wire at_top = (count == `UDRT_CNT_TOP);
    wire at_reload = (count == reload);
    wire roll = inc & (down ? at_reload : at_top);

    // External pin events exist outside up/down and baud use.
    wire ext_evt = external_enable_bit & pin_fall[1] & ~is_updown & (mode != udrt_pkg::UDRT_BAUD);
    wire cap_evt = ext_evt & (mode == udrt_pkg::UDRT_CAPTURE);
    wire rld_evt = ext_evt & (mode == udrt_pkg::UDRT_RELOAD);

    // Value after a wrap: FFFFh after underflow, zero in capture, reload otherwise.
    wire [15:0] wrap_val = down ? `UDRT_CNT_TOP :
        (mode == udrt_pkg::UDRT_CAPTURE) ? `UDRT_CNT_ZERO : reload;

    // Next count from hardware alone.
    wire [15:0] hw_count = roll ? wrap_val :
        rld_evt ? reload :
        inc ? (down ? count_dn : {high_up, low_up[7:0]}) : count;

    // Flags: hardware set wins over a software clear in the same cycle.
    wire ovf_set = roll & (mode != udrt_pkg::UDRT_BAUD) & ~clkout;
    wire ovf_base = wr_ctrl ? bus.wdata[`UDRT_CTRL_OVF] : overflow_flag;
    wire exf_base = wr_ctrl ? bus.wdata[`UDRT_CTRL_EXF] : external_flag;
    wire exf_toggle = roll & is_updown;
    wire nxt_ovf = ovf_set | ovf_base;
    wire nxt_exf = exf_toggle ? ~exf_base : (ext_evt | exf_base);

    // Read mux; unmapped addresses read zero and are answered with an error.
    assign bus.addr_ok = udrt_hit(bus.addr, `UDRT_OFF_CTRL) | udrt_hit(bus.addr, `UDRT_OFF_MODE) |
        udrt_hit(bus.addr, `UDRT_OFF_CNTL) | udrt_hit(bus.addr, `UDRT_OFF_CNTH) |
        udrt_hit(bus.addr, `UDRT_OFF_RLDL) | udrt_hit(bus.addr, `UDRT_OFF_RLDH);
    assign bus.rdata = udrt_hit(bus.addr, `UDRT_OFF_CTRL) ? ctrl_ff :
        udrt_hit(bus.addr, `UDRT_OFF_MODE) ? {6'h00, mode_ff} :
        udrt_hit(bus.addr, `UDRT_OFF_CNTL) ? count_low_byte_ff :
        udrt_hit(bus.addr, `UDRT_OFF_CNTH) ? count_high_byte_ff :
        udrt_hit(bus.addr, `UDRT_OFF_RLDL) ? reload_low_byte_ff :
        udrt_hit(bus.addr, `UDRT_OFF_RLDH) ? reload_high_byte_ff : 8'h00;

    // Prescalers run freely so that the first tick after run is at most one period away.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_ff <= 4'h0;
            half_ff <= 1'b0;
        end else begin
            pre_ff <= tick12 ? 4'h0 : pre_ff + 4'h1;
            half_ff <= ~half_ff;
        end
    end

    // Control registers; flag bits follow the set-wins merge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= `UDRT_RST_CTRL;
            mode_ff <= `UDRT_RST_MODE;
        end else begin
            ctrl_ff <= {nxt_ovf, nxt_exf, (wr_ctrl ? bus.wdata[5:0] : ctrl_ff[5:0])};
            if (wr_mode) begin
                mode_ff <= bus.wdata[1:0];
            end
        end
    end

    // Count bytes; a software write to a byte beats the hardware step for that byte.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_low_byte_ff <= `UDRT_RST_BYTE;
            count_high_byte_ff <= `UDRT_RST_BYTE;
        end else begin
            count_low_byte_ff <= wr_cntl ? bus.wdata : hw_count[7:0];
            count_high_byte_ff <= wr_cnth ? bus.wdata : hw_count[15:8];
        end
    end

    // Reload bytes; a capture event copies the live count here.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_low_byte_ff <= `UDRT_RST_BYTE;
            reload_high_byte_ff <= `UDRT_RST_BYTE;
        end else begin
            if (wr_rldl) begin
                reload_low_byte_ff <= bus.wdata;
            end else if (cap_evt) begin
                reload_low_byte_ff <= count[7:0];
            end
            if (wr_rldh) begin
                reload_high_byte_ff <= bus.wdata;
            end else if (cap_evt) begin
                reload_high_byte_ff <= count[15:8];
            end
        end
    end

    // Clock output: one toggle per wrap gives two wraps per period, hence the factor four.
    // The level freezes when clock-out stops, which is harmless since the pin is released.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out_ff <= 1'b0;
            pin_oe_ff <= 1'b0;
        end else begin
            if (clkout & roll) begin
                pin_out_ff <= ~pin_out_ff;
            end
            pin_oe_ff <= clkout;
        end
    end

    // Interrupt request and baud pulse; the external flag never interrupts in up/down mode.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
            baud_ff <= 1'b0;
        end else begin
            irq_ff <= overflow_flag | (external_flag & ~updown_enable_bit);
            baud_ff <= roll & (mode == udrt_pkg::UDRT_BAUD);
        end
    end

    assign count_pin_o = pin_out_ff;
    assign count_pin_oe = pin_oe_ff;
    assign timer_irq_req = irq_ff;
    assign baud_tick = baud_ff;

endmodule : udrt_timer

// ===== design/udrt_defs.svh
// Constants of the up/down reload timer: register offsets, bit positions,
// reset values and timing counts.
// Assumes an APB slave with an 8-bit byte address and 32-bit data.
`ifndef UDRT_DEFS_SVH
`define UDRT_DEFS_SVH

// Register byte offsets; each register takes one aligned word.
`define UDRT_OFF_CTRL 8'h00
`define UDRT_OFF_MODE 8'h04
`define UDRT_OFF_CNTL 8'h08
`define UDRT_OFF_CNTH 8'h0C
`define UDRT_OFF_RLDL 8'h10
`define UDRT_OFF_RLDH 8'h14

// Field positions in timer_control_register.
`define UDRT_CTRL_OVF 7
`define UDRT_CTRL_EXF 6
`define UDRT_CTRL_RCLK 5
`define UDRT_CTRL_TRANSMIT_CLOCK_SELECT 4
`define UDRT_CTRL_EXEN 3
`define UDRT_CTRL_RUN 2
`define UDRT_CTRL_CT 1
`define UDRT_CTRL_CPRL 0

// Field positions in mode_control_register.
`define UDRT_MODE_OE 1
`define UDRT_MODE_UPDOWN_ENABLE_BIT 0

// Reset values.
`define UDRT_RST_CTRL 8'h00
`define UDRT_RST_MODE 2'h0
`define UDRT_RST_BYTE 8'h00

// Count limits and prescaler figures, in oscillator cycles.
`define UDRT_CNT_TOP 16'hFFFF
`define UDRT_CNT_ZERO 16'h0000
`define UDRT_TIMER_DIV 12
`define UDRT_FAST_DIV 2
`define UDRT_PRE_LAST 4'(`UDRT_TIMER_DIV - 1)

`endif

// ===== design/udrt_pkg.sv
// Types shared by the up/down reload timer modules.
// Assumes udrt_defs.svh supplies the numeric constants.
package udrt_pkg;

    // Operating mode chosen by the serial clock selects, capture select and up/down enable.
    typedef enum logic [1:0] {
        UDRT_CAPTURE,
        UDRT_RELOAD,
        UDRT_UPDOWN,
        UDRT_BAUD
    } udrt_mode_t;

endpackage : udrt_pkg

// ===== design/udrt_regbus_if.sv
// Register access path between the APB slave and the timer core.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
interface udrt_regbus_if;
    logic wr_en; // One-cycle write strobe at the completing APB edge.
    logic [7:0] addr; // Byte address of the current transfer.
    logic [7:0] wdata; // Write data, low byte of the APB word.
    logic [7:0] rdata; // Read data of the addressed register.
    logic addr_ok; // High when the address hits a register.

    modport slave (output wr_en, output addr, output wdata, input rdata, input addr_ok);
    modport core (input wr_en, input addr, input wdata, output rdata, output addr_ok);
endinterface : udrt_regbus_if

// ===== design/udrt_pinsync.sv
// Two-flop synchronisers with falling-edge detect for the external pins.
// Assumes the pins are asynchronous to pclk.
`timescale 1ns/1ps
module udrt_pinsync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] pin_i,
    output logic [1:0] level_o,
    output logic [1:0] fall_o
);
    genvar gi;

    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
            logic meta_ff; // First stage, read only by the second.
            logic sync_ff; // Second stage, safe to use.
            logic prev_ff; // Delayed copy for edge detection.

            // Resets high so that no false falling edge appears after reset.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_ff <= 1'b1;
                    sync_ff <= 1'b1;
                    prev_ff <= 1'b1;
                end else begin
                    meta_ff <= pin_i[gi];
                    sync_ff <= meta_ff;
                    prev_ff <= sync_ff;
                end
            end

            assign level_o[gi] = sync_ff;
            assign fall_o[gi] = prev_ff & ~sync_ff;
        end
    endgenerate
endmodule : udrt_pinsync

// ===== design/udrt_apb.sv
// APB slave front end: no wait state, registered answer.
// Assumes the core decodes the address and returns read data combinationally.
`timescale 1ns/1ps
module udrt_apb (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    udrt_regbus_if.slave bus
);
    logic pready_ff; // Answer flag, high for the access cycle only.
    logic [7:0] prdata_ff; // Read data caught in the setup cycle.
    logic pslverr_ff; // Error answer for unmapped addresses.
    wire setup_w = psel & ~penable; // Setup cycle of a transfer.

    // The answer is prepared in the setup cycle so that every output comes from a flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            prdata_ff <= 8'h00;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= setup_w;
            prdata_ff <= (setup_w & ~pwrite) ? bus.rdata : 8'h00;
            pslverr_ff <= setup_w & ~bus.addr_ok;
        end
    end

    // A write takes effect only at the edge that completes the access, and never to an unmapped word.
    assign bus.wr_en = psel & penable & pready_ff & pwrite & bus.addr_ok;
    assign bus.addr = paddr;
    assign bus.wdata = pwdata[7:0];
    assign pready = pready_ff;
    assign prdata = {24'h000000, prdata_ff};
    assign pslverr = pslverr_ff;
endmodule : udrt_apb

// ===== tb/udrt_pin_model.sv
// Model of the outside world at the timer's pins: a count source and a direction line.
// Assumes the bench sets the levels; the shared pin is resolved here.
`timescale 1ns/1ps
module udrt_pin_model (
    input wire logic drive_level, // Level the external count source offers.
    input wire logic dir_level, // Level the direction source offers.
    input wire logic count_pin_oe, // High while the timer drives the shared pin.
    input wire logic count_pin_o, // Level the timer drives.
    output logic count_pin_i, // Resolved level of the shared pin.
    output logic direction_capture_pin_i // Direction line seen by the timer.
);
    // The source stands back while the timer drives, so the pin shows the generated clock.
    assign count_pin_i = count_pin_oe ? count_pin_o : drive_level;
    // High means count up, low means count down.
    assign direction_capture_pin_i = dir_level;
endmodule : udrt_pin_model

// ===== tb/udrt_timer_asserts.sv
// Port checker of the up/down reload timer.
// Assumes it is bound to udrt_timer and sees only its ports.
`timescale 1ns/1ps
module udrt_timer_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic count_pin_i,
    input wire logic count_pin_o,
    input wire logic count_pin_oe,
    input wire logic direction_capture_pin_i,
    input wire logic timer_irq_req,
    input wire logic baud_tick
);
    // Everything runs on pclk and rests while reset is low.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // A setup cycle of the bus.
    sequence s_setup;
        psel && !penable;
    endsequence
    // The access cycle that answers it.
    sequence s_answer;
        psel && penable && pready;
    endsequence
    AST_APB_ANSWER: assert property (s_setup |=> s_answer)
        else $error("access cycle did not answer the setup");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready stood longer than one cycle");
    AST_READY_CAUSE: assert property (pready |-> $past(psel) && !$past(penable))
        else $error("ready without a preceding setup");
    AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    AST_ERR_READS_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("refused access returned data");
    AST_RESET_QUIET: assert property ($rose(presetn) |-> !pready && !timer_irq_req && !count_pin_oe && !baud_tick)
        else $error("output active right after reset");
    AST_BAUD_SPACING: assert property (baud_tick |=> !baud_tick)
        else $error("baud ticks closer than one step");
    AST_CLKOUT_HALF: assert property ($changed(count_pin_o) |=> $stable(count_pin_o))
        else $error("clock output half period below two cycles");
endmodule : udrt_timer_asserts

bind udrt_timer udrt_timer_asserts udrt_timer_asserts_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .count_pin_i(count_pin_i),
    .count_pin_o(count_pin_o), .count_pin_oe(count_pin_oe), .direction_capture_pin_i(direction_capture_pin_i),
    .timer_irq_req(timer_irq_req), .baud_tick(baud_tick)
);

// ===== tb/test_updown_reload_timer_clockout.sv
// Self-checking bench of the up/down reload timer, driven over APB and its pins.
// Assumes the checker is bound to udrt_timer by its own file.
`timescale 1ns/1ps
`include "udrt_defs.svh"
module test_updown_reload_timer_clockout;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic drive_level = 1'h1; // Count source idles high, so no false edge.
    logic dir_level = 1'h1;
    logic pready, pslverr, count_pin_i, count_pin_o, count_pin_oe, dir_pin, timer_irq_req, baud_tick;
    logic [31:0] prdata, rdv, rng;
    logic last_err;
    logic [15:0] rl;
    int miscompares = 0;
    int samples_checked = 0;
    int gap;
    // Free-running 250 MHz clock.
    always #2 pclk = ~pclk;
    udrt_timer udrt_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .count_pin_i(count_pin_i), .count_pin_o(count_pin_o), .count_pin_oe(count_pin_oe),
        .direction_capture_pin_i(dir_pin), .timer_irq_req(timer_irq_req), .baud_tick(baud_tick));
    udrt_pin_model udrt_pin_model_i (.drive_level(drive_level), .dir_level(dir_level),
        .count_pin_oe(count_pin_oe), .count_pin_o(count_pin_o), .count_pin_i(count_pin_i),
        .direction_capture_pin_i(dir_pin));
    // Repeatable random source.
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    // Next count going up, and going down, against a reload value.
    function automatic logic [15:0] up_next(input logic [15:0] c, input logic [15:0] r);
        return (c == 16'hFFFF) ? r : c + 16'h1;
    endfunction : up_next
    function automatic logic [15:0] down_next(input logic [15:0] c, input logic [15:0] r);
        return (c == r) ? 16'hFFFF : c - 16'h1;
    endfunction : down_next
    // Half period of the output clock in pclk cycles.
    function automatic logic [31:0] half(input logic [15:0] r);
        return 32'h2 * (32'h10000 - {16'h0, r});
    endfunction : half
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk
    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test
    task automatic timeout;
        miscompares++;
        finish_test();
    endtask : timeout
    // One APB transfer; the request is held until ready is seen at an edge.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int i;
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'h1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'h1) break;
        end
        if (i == 16) timeout();
        rdv = prdata;
        last_err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'h1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        bus(1'h0, a, 8'h00);
    endtask : rd
    // Writes a 16-bit value as its low byte, then its high byte one word above.
    task automatic load16(input logic [7:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 8'h04, v[15:8]);
    endtask : load16
    task automatic check_count(input logic [15:0] e);
        rd(`UDRT_OFF_CNTL);
        chk(rdv, {24'h0, e[7:0]});
        rd(`UDRT_OFF_CNTH);
        chk(rdv, {24'h0, e[15:8]});
    endtask : check_count
    // Falling edges on the count pin, spaced for the two-flop synchroniser.
    task automatic pulses(input int n);
        repeat (n) begin
            drive_level <= 1'h0;
            repeat (4) @(posedge pclk);
            drive_level <= 1'h1;
            repeat (4) @(posedge pclk);
        end
    endtask : pulses
    // Cycles until the next baud tick or the next output toggle.
    task automatic next_event(input logic use_tick, output int n);
        logic last;
        last = count_pin_o;
        for (n = 1; n < 400; n++) begin
            @(posedge pclk);
            if (use_tick ? baud_tick === 1'h1 : count_pin_o !== last) break;
        end
        if (n == 400) timeout();
    endtask : next_event
    initial begin
        rng = 32'h209F;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        // All six registers reset to zero; the seventh word is unmapped and refused.
        for (int k = 0; k < 7; k++) begin
            rd(8'(k * 4));
            chk(rdv, 32'h0);
            chk({31'h0, last_err}, {31'h0, k == 6});
        end
        // Event counting through an overflow; reload low byte FF makes the next step carry.
        rng = xs(rng);
        rl = {rng[15:8], 8'hFF};
        load16(`UDRT_OFF_RLDL, rl);
        load16(`UDRT_OFF_CNTL, 16'hFFFE);
        wr(`UDRT_OFF_CTRL, 8'h06);
        pulses(3);
        check_count(up_next(up_next(up_next(16'hFFFE, rl), rl), rl));
        rd(`UDRT_OFF_CTRL);
        chk(rdv, 32'h86);
        chk({31'h0, timer_irq_req}, 32'h1);
        // Stopped counter ignores edges.
        wr(`UDRT_OFF_CTRL, 8'h02);
        pulses(2);
        check_count(up_next(up_next(up_next(16'hFFFE, rl), rl), rl));
        // Timer use: one step per twelve clocks over a 123-cycle run window.
        load16(`UDRT_OFF_CNTL, 16'h0000);
        wr(`UDRT_OFF_CTRL, 8'h04);
        repeat (120) @(posedge pclk);
        wr(`UDRT_OFF_CTRL, 8'h00);
        rd(`UDRT_OFF_CNTL);
        chk({31'h0, rdv inside {32'hA, 32'hB}}, 32'h1);
        // Down count under the direction pin: underflow at the reload value.
        wr(`UDRT_OFF_MODE, 8'h01);
        dir_level <= 1'h0;
        rng = xs(rng);
        rl = {1'h0, rng[30:16]};
        load16(`UDRT_OFF_RLDL, rl);
        load16(`UDRT_OFF_CNTL, rl + 16'h1);
        wr(`UDRT_OFF_CTRL, 8'h06);
        pulses(2);
        check_count(down_next(down_next(rl + 16'h1, rl), rl));
        rd(`UDRT_OFF_CTRL);
        chk(rdv, 32'hC6);
        // External flag alone raises no request in up/down use.
        wr(`UDRT_OFF_CTRL, 8'h46);
        // The request is a registered view of the flags, so let one edge pass before looking.
        @(posedge pclk);
        chk({31'h0, timer_irq_req}, 32'h0);
        dir_level <= 1'h1;
        pulses(1);
        check_count(up_next(16'hFFFF, rl));
        rd(`UDRT_OFF_CTRL);
        chk(rdv, 32'h86);
        // Clock-out set up in the documented order.
        wr(`UDRT_OFF_CTRL, 8'h00);
        wr(`UDRT_OFF_MODE, 8'h02);
        rng = xs(rng);
        rl = {12'hFFF, rng[3:0]};
        load16(`UDRT_OFF_RLDL, rl);
        load16(`UDRT_OFF_CNTL, rl);
        wr(`UDRT_OFF_CTRL, 8'h04);
        next_event(1'h0, gap);
        next_event(1'h0, gap);
        chk(32'(gap), half(rl));
        next_event(1'h0, gap);
        chk(32'(gap), half(rl));
        chk({30'h0, count_pin_oe, count_pin_i}, {30'h0, 1'h1, count_pin_o});
        chk({31'h0, timer_irq_req}, 32'h0);
        // Baud use beside the clock output; the capture select is set but must be ignored.
        wr(`UDRT_OFF_CTRL, 8'h15);
        next_event(1'h1, gap);
        next_event(1'h1, gap);
        chk(32'(gap), half(rl));
        next_event(1'h0, gap);
        next_event(1'h0, gap);
        chk(32'(gap), half(rl));
        rd(`UDRT_OFF_CTRL);
        chk(rdv, 32'h15);
        finish_test();
    end
endmodule : test_updown_reload_timer_clockout
